// ==== hw/edsp_pkg.sv ====
package edsp_pkg;

    // Address widths
    localparam int BASE_W = 16;
    localparam int PAGE_W = 10;
    localparam int OFS_W = 15;
    localparam int EXT_W = PAGE_W + OFS_W;

    // Top bit of the base effective address selects the paged half
    localparam int EA_TOP_BIT = 15;

    // Page register values
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 10'h000;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h001;

    // One core access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [BASE_W-1:0] addr;
    } edsp_req_t;

    // One translated access
    typedef struct packed {
        logic valid;
        logic write;
        logic [EXT_W-1:0] addr;
    } edsp_xlat_t;

    // Software update of a page register
    typedef struct packed {
        logic wr_en;
        logic [PAGE_W-1:0] value;
    } edsp_page_wr_t;

endpackage : edsp_pkg

// ==== hw/edsp_xlate.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Lower-half base addresses are reachable whatever the pages hold.
// - With the top address bit clear the access lands in extended page 0.
// - An upper-half access through a zero page raises an address error.
// - Reset loads both the read page and the write page with one.
// - A write of zero to a page register is ignored, the old value kept.
// - Pages other than 0 are reached only by upper-half base addresses.
// - An upper-half address is the page times 32 KB plus the low 15 bits.
module edsp_xlate (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Core access request
    input wire edsp_pkg::edsp_req_t core_req,
    // Software page register updates
    input wire edsp_pkg::edsp_page_wr_t data_read_page_wr,
    input wire edsp_pkg::edsp_page_wr_t data_write_page_wr,
    // Translated access and trap
    output edsp_pkg::edsp_xlat_t ext_acc,
    output logic addr_error_trap,
    // Current page register contents
    output logic [edsp_pkg::PAGE_W-1:0] data_read_page,
    output logic [edsp_pkg::PAGE_W-1:0] data_write_page
);

    // Page register entries, one per access direction
    localparam int NUM_PAGES = 2;
    localparam int RD_PAGE = 0;
    localparam int WR_PAGE = 1;

    // Fields of the core request
    logic req_valid;
    logic req_write;
    logic [edsp_pkg::BASE_W-1:0] req_addr;

    // Paged half select
    logic effective_address_top_bit;

    // In-page offset
    logic [edsp_pkg::OFS_W-1:0] low_bits;

    // Page register storage, addressed by the access direction
    edsp_pkg::edsp_page_wr_t page_wr [NUM_PAGES];
    logic [edsp_pkg::PAGE_W-1:0] page_q [NUM_PAGES];
    logic [edsp_pkg::PAGE_W-1:0] page_d [NUM_PAGES];

    // Per-entry update acceptance and zero flag
    logic [NUM_PAGES-1:0] page_take;
    logic [NUM_PAGES-1:0] page_zero;

    // Page selected for the current access
    logic sel_idx;
    logic [edsp_pkg::PAGE_W-1:0] data_page_select;
    logic sel_zero;

    // Access classification
    logic lower_hit;
    logic upper_hit;
    logic upper_ok;
    logic upper_bad;

    // Extended address pieces
    logic [edsp_pkg::PAGE_W-1:0] eff_page;
    logic [edsp_pkg::EXT_W-1:0] ext_addr;

    // Translated access, next and registered
    logic acc_valid_d;
    logic acc_valid_q;
    logic acc_write_d;
    logic acc_write_q;
    logic [edsp_pkg::EXT_W-1:0] acc_addr_d;
    logic [edsp_pkg::EXT_W-1:0] acc_addr_q;

    // Trap pulse, next and registered
    logic trap_d;
    logic trap_q;

    // Split the core request into its fields
    assign req_valid = core_req.valid;
    assign req_write = core_req.write;
    assign req_addr = core_req.addr;

    // Top bit picks the paged half
    assign effective_address_top_bit = req_addr[edsp_pkg::EA_TOP_BIT];

    // The rest of the base address is the in-page offset
    assign low_bits = req_addr[edsp_pkg::OFS_W-1:0];

    // Software updates gathered per page entry
    assign page_wr[RD_PAGE] = data_read_page_wr;
    assign page_wr[WR_PAGE] = data_write_page_wr;

    // One page register per access direction; a zero write is dropped
    // at the input, so a register never leaves the legal page range
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PAGES; gi = gi + 1)
        begin : g_page
            // A zero value never enters the register
            assign page_take[gi] = page_wr[gi].wr_en
                && (page_wr[gi].value != edsp_pkg::PAGE_ZERO);

            // New page when taken, old page otherwise
            assign page_d[gi] = page_take[gi] ? page_wr[gi].value
                : page_q[gi];

            // Zero page flag, the trap's guard
            assign page_zero[gi] = (page_q[gi] == edsp_pkg::PAGE_ZERO);

            // Page register, reset to the first page above page 0
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    page_q[gi] <= edsp_pkg::PAGE_RESET;
                end
                else
                begin
                    page_q[gi] <= page_d[gi];
                end
            end
        end
    endgenerate

    // Reads use the read entry, writes the write entry
    assign sel_idx = req_write;

    // Selected page and its zero flag
    assign data_page_select = page_q[sel_idx];
    assign sel_zero = page_zero[sel_idx];

    // Lower half always lands in page 0
    assign lower_hit = req_valid && !effective_address_top_bit;

    // Upper half goes through the selected page
    assign upper_hit = req_valid && effective_address_top_bit;

    // Upper-half access through a zero page is refused with a trap;
    // out of reach while zero writes are dropped, kept as a guard
    assign upper_bad = upper_hit && sel_zero;
    assign upper_ok = upper_hit && !sel_zero;

    // Page 0 for the lower half, the selected page for the upper half
    assign eff_page = effective_address_top_bit
        ? data_page_select : edsp_pkg::PAGE_ZERO;

    // Page value times 32 KB plus the in-page offset
    assign ext_addr = {eff_page, low_bits};

    // Passed on unless trapped
    assign acc_valid_d = lower_hit || upper_ok;

    // Direction and address travel with the access
    assign acc_write_d = req_write;
    assign acc_addr_d = ext_addr;

    // Next trap pulse
    assign trap_d = upper_bad;

    // Access valid pulse, one cycle per accepted request
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_valid_q <= 1'b0;
        end
        else
        begin
            acc_valid_q <= acc_valid_d;
        end
    end

    // Access direction
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_write_q <= 1'b0;
        end
        else
        begin
            acc_write_q <= acc_write_d;
        end
    end

    // Extended address
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_addr_q <= '0;
        end
        else
        begin
            acc_addr_q <= acc_addr_d;
        end
    end

    // Trap pulse, one cycle per refused access
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trap_q <= 1'b0;
        end
        else
        begin
            trap_q <= trap_d;
        end
    end

    // Translated access output
    assign ext_acc = '{
        valid: acc_valid_q,
        write: acc_write_q,
        addr: acc_addr_q
    };

    // Trap and page outputs
    assign addr_error_trap = trap_q;
    assign data_read_page = page_q[RD_PAGE];
    assign data_write_page = page_q[WR_PAGE];

endmodule : edsp_xlate

// ==== bench/edsp_core_model.sv ====
`timescale 1ns/1ps
module edsp_core_model (
    // Access command from the bench
    input wire logic go,
    input wire logic [16:0] cmd,
    // Request as the core presents it
    output edsp_pkg::edsp_req_t core_req
);
    // Core issues reads and writes anywhere in the base space
    assign core_req = {go, cmd};
endmodule : edsp_core_model

// ==== bench/edsp_checker.sv ====
`timescale 1ns/1ps
module edsp_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Watched ports
    input wire edsp_pkg::edsp_req_t core_req,
    input wire edsp_pkg::edsp_page_wr_t data_read_page_wr,
    input wire edsp_pkg::edsp_page_wr_t data_write_page_wr,
    input wire edsp_pkg::edsp_xlat_t ext_acc,
    input wire logic addr_error_trap,
    input wire logic [9:0] data_read_page,
    input wire logic [9:0] data_write_page
);
    // Request decode and expected translated access
    wire lo = core_req.valid && !core_req.addr[15];
    wire hi = core_req.valid && core_req.addr[15];
    wire [9:0] pg = core_req.write ? data_write_page : data_read_page;
    wire [26:0] xa = {1'b1, core_req.write, lo ? 10'h000 : pg,
        core_req.addr[14:0]};
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Translation, trap and page register relations
    a_addr_map: assert property (lo || hi && pg != 10'h000
        |=> ext_acc == $past(xa)) else $error("bad translation");
    a_zero_trap: assert property (hi && pg == 10'h000
        |=> addr_error_trap && !ext_acc.valid) else $error("no trap");
    a_trap_cause: assert property (addr_error_trap |-> $past(hi))
        else $error("stray trap");
    a_idle_quiet: assert property (!core_req.valid |=> !ext_acc.valid
        && !addr_error_trap) else $error("stray access");
    a_reset_page: assert property ($rose(arst_n) |->
        data_read_page == 10'h001 && data_write_page == 10'h001)
        else $error("bad reset page");
    a_zero_kept: assert property (data_write_page_wr == 11'h400
        |=> $stable(data_write_page)) else $error("zero page taken");
    a_page_load: assert property (data_write_page_wr.wr_en
        && data_write_page_wr.value != 10'h000 |=> data_write_page
        == $past(data_write_page_wr.value)) else $error("page not loaded");
    a_read_kept: assert property (data_read_page_wr == 11'h400
        |=> $stable(data_read_page)) else $error("zero read page taken");
    a_read_load: assert property (data_read_page_wr.wr_en
        && data_read_page_wr.value != 10'h000 |=> data_read_page
        == $past(data_read_page_wr.value))
        else $error("read page not loaded");
    a_read_nonzero: assert property (data_read_page != 10'h000)
        else $error("read page zero");
    // Main scenarios
    c_low_access: cover property (lo);
    c_high_write: cover property (hi && core_req.write);
    c_zero_write: cover property (data_write_page_wr == 11'h400);
endmodule : edsp_checker

bind edsp_xlate edsp_checker u_edsp_checker (.mclk, .arst_n, .core_req,
    .data_read_page_wr, .data_write_page_wr, .ext_acc, .addr_error_trap,
    .data_read_page, .data_write_page);

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic go = 1'b0;
    logic [16:0] cmd = 17'h00000;
    edsp_pkg::edsp_page_wr_t data_read_page_wr = '0;
    edsp_pkg::edsp_page_wr_t data_write_page_wr = '0;
    edsp_pkg::edsp_req_t core_req;
    edsp_pkg::edsp_xlat_t ext_acc;
    logic addr_error_trap;
    logic [9:0] data_read_page, data_write_page;
    int bad_count = 0, check_count = 0, rp = 1, wp = 1, e, pg;
    int q[$];
    `define CHK(n, x, y) begin check_count++; if ((x) !== (y)) begin \
        bad_count++; $display("unexpected %s exp %h saw %h", n, x, y); end end

    // Clock and the two sides of the translator
    always #2 mclk = ~mclk;
    edsp_core_model u_edsp_core_model (.go, .cmd, .core_req);
    edsp_xlate u_edsp_xlate (.mclk, .arst_n, .core_req, .data_read_page_wr,
        .data_write_page_wr, .ext_acc, .addr_error_trap, .data_read_page,
        .data_write_page);

    // Reference model: check last cycle's result, then take this cycle's
    always @(posedge mclk)
    begin
        e = q.size() ? q.pop_front() : -1;
        if (!arst_n)
        begin
            q = {};
            rp = 1;
            wp = 1;
        end
        else
        begin
            `CHK("valid", e >= 0, ext_acc.valid)
            `CHK("trap", e == -2, addr_error_trap)
            if (e >= 0) `CHK("access", 27'(e), ext_acc)
            `CHK("read page", 10'(rp), data_read_page)
            `CHK("write page", 10'(wp), data_write_page)
            pg = !cmd[15] ? 0 : cmd[16] ? wp : rp;
            e = (1 << 26) | (cmd[16] << 25) | (pg << 15) | cmd[14:0];
            q.push_back(!go ? -1 : cmd[15] && pg == 0 ? -2 : e);
            if (data_read_page_wr.wr_en && data_read_page_wr.value != 0)
                rp = data_read_page_wr.value;
            if (data_write_page_wr.wr_en && data_write_page_wr.value != 0)
                wp = data_write_page_wr.value;
        end
    end

    // Random traffic, zero page writes and a reset in mid-run
    initial
    begin
        void'($urandom(32'h9528));
        repeat (3) @(posedge mclk);
        for (int k = 0; k < 400; k++)
        begin
            @(negedge mclk);
            arst_n = k != 200;
            go = $urandom_range(3) != 0;
            cmd = 17'($urandom);
            data_read_page_wr = {k % 5 == 0, k % 3 ? 10'($urandom) : 10'h000};
            data_write_page_wr = {k % 4 == 0, k % 6 ? 10'($urandom) : 10'h000};
        end
        // Let the last two results reach the model's checks
        repeat (2) @(negedge mclk);
        results;
    end

    // Cut a hang short
    initial
    begin
        #20000;
        bad_count++;
        results;
    end

    task results;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
endmodule : testbench
